/* File: core/secl_consts.vh */
// constants for the eeprom configuration loader
`ifndef SECL_CONSTS_VH
`define SECL_CONSTS_VH

// clock and bus timing
`define SECL_CLK_PERIOD_NS 50
`define SECL_SLOW_BIT_NS   10000
`define SECL_FAST_BIT_NS   2500
`define SECL_SLOW_QTR      ((`SECL_SLOW_BIT_NS + 4 * `SECL_CLK_PERIOD_NS - 1) / (4 * `SECL_CLK_PERIOD_NS))
`define SECL_FAST_QTR      ((`SECL_FAST_BIT_NS + 4 * `SECL_CLK_PERIOD_NS - 1) / (4 * `SECL_CLK_PERIOD_NS))

// byte engine commands
`define SECL_CMD_START 2'h0
`define SECL_CMD_STOP  2'h1
`define SECL_CMD_WRITE 2'h2
`define SECL_CMD_READ  2'h3

// eeprom bus address fixed bits 6:4
`define SECL_EE_ADDR_HI 3'h5

// configuration block types
`define SECL_TYPE_SINGLE 2'h0
`define SECL_TYPE_SEQ    2'h1
`define SECL_TYPE_BAD    2'h2
`define SECL_TYPE_DONE   2'h3

// block byte positions
`define SECL_POS_TYPE   3'h0
`define SECL_POS_ADDR_L 3'h1
`define SECL_POS_ADDR_H 3'h2
`define SECL_POS_CNT_L  3'h3
`define SECL_POS_CNT_H  3'h4
`define SECL_POS_DATA0  3'h3
`define SECL_POS_DATA3  3'h6
`define SECL_POS_CSUM   3'h1

// checksum, blank and rollover figures
`define SECL_SUM_GOOD   8'hFF
`define SECL_BLANK_BYTE 8'hFF
`define SECL_BLANK_LAST 16'h00FF
`define SECL_EE_TOP     16'hFFFF

// switch modes that load from eeprom, one bit per mode
`define SECL_EE_MODE_MASK 16'h0001

`endif

/* File: core/secl_i2c_byte.v */
// two-wire master byte engine: start, stop, byte write, byte read
`default_nettype none
`include "secl_consts.vh"

module secl_i2c_byte (
  input  wire       clk_sys_i,
  input  wire       rst_i,
  input  wire [7:0] quarter_i,
  input  wire       cmd_valid_i,
  input  wire [1:0] cmd_i,
  input  wire [7:0] din_i,
  input  wire       ack_i,
  output wire       busy_o,
  output wire       done_o,
  output wire [7:0] dout_o,
  output wire       nack_o,
  input  wire       scl_i,
  output wire       scl_oe_o,
  input  wire       sda_i,
  output wire       sda_oe_o
);

  reg       busy_reg;
  reg       done_reg;
  reg       nack_reg;
  reg       scl_oe_reg;
  reg       sda_oe_reg;
  reg [1:0] cmd_reg;
  reg [7:0] sh_reg;
  reg       ack_reg;
  reg [3:0] bit_reg;
  reg [1:0] q_reg;
  reg [7:0] cnt_reg;
  reg       scl_m_reg;
  reg       scl_s_reg;
  reg       sda_m_reg;
  reg       sda_s_reg;
  reg       drive_low;

  wire       is_byte    = cmd_reg[1];
  wire       last       = !is_byte || (bit_reg == 4'h8);
  wire [7:0] quarter_m1 = quarter_i - 8'h01;

  assign busy_o   = busy_reg;
  assign done_o   = done_reg;
  assign dout_o   = sh_reg;
  assign nack_o   = nack_reg;
  assign scl_oe_o = scl_oe_reg;
  assign sda_oe_o = sda_oe_reg;

  // data bit or acknowledge to drive in this bit slot
  always @* begin
    if (bit_reg == 4'h8)
      drive_low = (cmd_reg == `SECL_CMD_READ) ? ack_reg : 1'b0;
    else
      drive_low = (cmd_reg == `SECL_CMD_WRITE) ? ~sh_reg[7] : 1'b0;
  end

  // pin synchronisers
  always @(posedge clk_sys_i) begin
    scl_m_reg <= scl_i;
    scl_s_reg <= scl_m_reg;
    sda_m_reg <= sda_i;
    sda_s_reg <= sda_m_reg;
  end

  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      busy_reg   <= 1'b0;
      done_reg   <= 1'b0;
      nack_reg   <= 1'b0;
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      cmd_reg    <= `SECL_CMD_START;
      sh_reg     <= 8'h00;
      ack_reg    <= 1'b0;
      bit_reg    <= 4'h0;
      q_reg      <= 2'h0;
      cnt_reg    <= 8'h00;
    end else begin
      done_reg <= 1'b0;
      if (!busy_reg) begin
        if (cmd_valid_i) begin
          busy_reg <= 1'b1;
          cmd_reg  <= cmd_i;
          sh_reg   <= din_i;
          ack_reg  <= ack_i;
          nack_reg <= 1'b0;
          bit_reg  <= 4'h0;
          q_reg    <= 2'h0;
          cnt_reg  <= quarter_m1;
        end
      end else if (cnt_reg != 8'h00) begin
        cnt_reg <= cnt_reg - 8'h01;
      end else if (q_reg != 2'h2 || scl_s_reg) begin
        // quarter 2 waits while a slave stretches the clock
        cnt_reg <= quarter_m1;
        q_reg   <= q_reg + 2'h1;
        case (q_reg)
          2'h0: begin
            if (cmd_reg == `SECL_CMD_START)
              sda_oe_reg <= 1'b0;
            else if (cmd_reg == `SECL_CMD_STOP)
              sda_oe_reg <= 1'b1;
            else
              sda_oe_reg <= drive_low;
          end
          2'h1: begin
            scl_oe_reg <= 1'b0;
          end
          2'h2: begin
            if (cmd_reg == `SECL_CMD_START)
              sda_oe_reg <= 1'b1;
            else if (cmd_reg == `SECL_CMD_STOP)
              sda_oe_reg <= 1'b0;
            else if (bit_reg == 4'h8)
              nack_reg <= sda_s_reg;
            else
              sh_reg <= {sh_reg[6:0], sda_s_reg};
          end
          default: begin
            if (cmd_reg != `SECL_CMD_STOP)
              scl_oe_reg <= 1'b1;
            if (last) begin
              busy_reg <= 1'b0;
              done_reg <= 1'b1;
            end else begin
              bit_reg <= bit_reg + 4'h1;
            end
          end
        endcase
      end
    end
  end

endmodule
`default_nettype wire

/* File: core/secl_loader.v */
// eeprom configuration loader with slave register and eeprom access paths
`default_nettype none
`include "secl_consts.vh"

module secl_loader #(
  parameter [15:0] EE_MODE_MASK = `SECL_EE_MODE_MASK
) (
  input  wire        clk_sys_i,
  input  wire        rst_i,
  input  wire        master_slow_mode_strap_i,
  input  wire [3:0]  switch_operating_mode_i,
  input  wire [3:0]  master_addr_straps_i,
  input  wire        ignore_checksum_errors_i,
  input  wire        scl_i,
  output wire        scl_o,
  output wire        scl_oe_o,
  input  wire        sda_i,
  output wire        sda_o,
  output wire        sda_oe_o,
  output wire [17:0] reg_addr_o,
  output wire [31:0] reg_wdata_o,
  output wire        reg_wr_o,
  output wire        reg_rd_o,
  input  wire        reg_addr_mapped_i,
  input  wire [31:0] reg_rdata_i,
  output wire        slv_ready_o,
  input  wire        slv_reg_req_i,
  input  wire        slv_reg_we_i,
  input  wire [17:0] slv_reg_addr_i,
  input  wire [31:0] slv_reg_wdata_i,
  output wire        slv_reg_ack_o,
  output wire [31:0] slv_reg_rdata_o,
  input  wire        slv_ee_req_i,
  input  wire        slv_ee_we_i,
  input  wire [15:0] slv_ee_addr_i,
  input  wire [7:0]  slv_ee_wdata_i,
  output wire        slv_ee_ack_o,
  output wire [7:0]  slv_ee_rdata_o,
  output wire [7:0]  master_clock_prescaler_o,
  output wire        loading_o,
  output wire        load_complete_flag_o,
  output wire        rollover_error_o,
  output wire        blank_eeprom_o,
  output wire        unmapped_write_flag_o,
  output wire        checksum_error_flag_o,
  output wire        nack_error_o,
  output wire        reset_halt_flag_o
);

  localparam [3:0] S_BOOT = 4'h0;
  localparam [3:0] S_ST1  = 4'h1;
  localparam [3:0] S_DEVW = 4'h2;
  localparam [3:0] S_AH   = 4'h3;
  localparam [3:0] S_AL   = 4'h4;
  localparam [3:0] S_ST2  = 4'h5;
  localparam [3:0] S_DEVR = 4'h6;
  localparam [3:0] S_RD   = 4'h7;
  localparam [3:0] S_CONS = 4'h8;
  localparam [3:0] S_WR   = 4'h9;
  localparam [3:0] S_ABRT = 4'hA;
  localparam [3:0] S_STOP = 4'hB;
  localparam [3:0] S_FIN  = 4'hC;
  localparam [3:0] S_IDLE = 4'hD;
  localparam [3:0] S_EWD  = 4'hE;
  localparam [3:0] S_XREG = 4'hF;

  localparam integer SLOW_QTR_INT = `SECL_SLOW_QTR;
  localparam integer FAST_QTR_INT = `SECL_FAST_QTR;
  localparam [7:0]   SLOW_QTR     = SLOW_QTR_INT[7:0];
  localparam [7:0]   FAST_QTR     = FAST_QTR_INT[7:0];

  reg [3:0]  state_reg;
  reg        issued_reg;
  reg        ext_reg;
  reg        xwe_reg;
  reg [15:0] ee_addr_reg;
  reg [7:0]  ee_wdata_reg;
  reg [7:0]  presc_reg;
  reg [7:0]  sum_reg;
  reg        blank_reg;
  reg        probe_reg;
  reg        done_bad_reg;
  reg        ack_sent_reg;
  reg        wrap_reg;
  reg [2:0]  pos_reg;
  reg [1:0]  type_reg;
  reg        seq_data_reg;
  reg [15:0] daddr_reg;
  reg [15:0] count_reg;
  reg [31:0] data_reg;
  reg [17:0] reg_addr_reg;
  reg [31:0] reg_wdata_reg;
  reg [31:0] slv_rdata_reg;
  reg        slv_reg_ack_reg;
  reg [7:0]  slv_ee_rdata_reg;
  reg        slv_ee_ack_reg;
  reg        loading_reg;
  reg        complete_reg;
  reg        rollover_reg;
  reg        blank_flag_reg;
  reg        unmapped_reg;
  reg        cserr_reg;
  reg        nack_err_reg;
  reg        halt_reg;
  reg        slow_m_reg;
  reg        slow_s_reg;
  reg [3:0]  mode_m_reg;
  reg [3:0]  mode_s_reg;
  reg [3:0]  straps_m_reg;
  reg [3:0]  straps_s_reg;
  reg [1:0]  eng_cmd;
  reg [7:0]  eng_din;
  reg        eng_ack;
  reg        eng_use;

  wire       eng_busy;
  wire       eng_done;
  wire [7:0] eng_dout;
  wire       eng_nack;
  wire       eng_valid = eng_use && !issued_reg && !eng_busy;
  wire [7:0] b         = eng_dout;
  wire [7:0] sum_n     = sum_reg + b;
  wire       blank_n   = blank_reg && (b == `SECL_BLANK_BYTE);
  wire [6:0] ee_dev    = {`SECL_EE_ADDR_HI, straps_s_reg};
  wire       rd_ack    = !ext_reg && !(type_reg == `SECL_TYPE_DONE && pos_reg == `SECL_POS_CSUM
                                       && !blank_reg && !probe_reg);
  wire [3:0] fin_st    = ack_sent_reg ? S_ABRT : S_STOP;
  wire       csum_bad  = !ignore_checksum_errors_i && (sum_n != `SECL_SUM_GOOD);

  assign scl_o                    = 1'b0;
  assign sda_o                    = 1'b0;
  assign reg_addr_o               = reg_addr_reg;
  assign reg_wdata_o              = reg_wdata_reg;
  assign reg_wr_o                 = ((state_reg == S_WR) || (state_reg == S_XREG && xwe_reg))
                                    && reg_addr_mapped_i;
  assign reg_rd_o                 = (state_reg == S_XREG) && !xwe_reg;
  assign slv_ready_o              = (state_reg == S_IDLE);
  assign slv_reg_ack_o            = slv_reg_ack_reg;
  assign slv_reg_rdata_o          = slv_rdata_reg;
  assign slv_ee_ack_o             = slv_ee_ack_reg;
  assign slv_ee_rdata_o           = slv_ee_rdata_reg;
  assign master_clock_prescaler_o = presc_reg;
  assign loading_o                = loading_reg;
  assign load_complete_flag_o     = complete_reg;
  assign rollover_error_o         = rollover_reg;
  assign blank_eeprom_o           = blank_flag_reg;
  assign unmapped_write_flag_o    = unmapped_reg;
  assign checksum_error_flag_o    = cserr_reg;
  assign nack_error_o             = nack_err_reg;
  assign reset_halt_flag_o        = halt_reg;

  // strap and mode synchronisers
  always @(posedge clk_sys_i) begin
    slow_m_reg   <= master_slow_mode_strap_i;
    slow_s_reg   <= slow_m_reg;
    mode_m_reg   <= switch_operating_mode_i;
    mode_s_reg   <= mode_m_reg;
    straps_m_reg <= master_addr_straps_i;
    straps_s_reg <= straps_m_reg;
  end

  // command for the byte engine in each bus state
  always @* begin
    eng_use = 1'b1;
    eng_cmd = `SECL_CMD_WRITE;
    eng_din = 8'h00;
    eng_ack = 1'b0;
    case (state_reg)
      S_ST1, S_ST2: eng_cmd = `SECL_CMD_START;
      S_DEVW: eng_din = {ee_dev, 1'b0};
      S_AH:   eng_din = ee_addr_reg[15:8];
      S_AL:   eng_din = ee_addr_reg[7:0];
      S_DEVR: eng_din = {ee_dev, 1'b1};
      S_EWD:  eng_din = ee_wdata_reg;
      S_RD: begin
        eng_cmd = `SECL_CMD_READ;
        eng_ack = rd_ack;
        eng_use = ext_reg || !wrap_reg;
      end
      S_ABRT: eng_cmd = `SECL_CMD_READ;
      S_STOP: eng_cmd = `SECL_CMD_STOP;
      default: eng_use = 1'b0;
    endcase
  end

  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_reg        <= S_BOOT;
      issued_reg       <= 1'b0;
      ext_reg          <= 1'b0;
      xwe_reg          <= 1'b0;
      ee_addr_reg      <= 16'h0000;
      ee_wdata_reg     <= 8'h00;
      presc_reg        <= FAST_QTR;
      sum_reg          <= 8'h00;
      blank_reg        <= 1'b1;
      probe_reg        <= 1'b0;
      done_bad_reg     <= 1'b0;
      ack_sent_reg     <= 1'b0;
      wrap_reg         <= 1'b0;
      pos_reg          <= `SECL_POS_TYPE;
      type_reg         <= `SECL_TYPE_SINGLE;
      seq_data_reg     <= 1'b0;
      daddr_reg        <= 16'h0000;
      count_reg        <= 16'h0000;
      data_reg         <= 32'h0000_0000;
      reg_addr_reg     <= 18'h0_0000;
      reg_wdata_reg    <= 32'h0000_0000;
      slv_rdata_reg    <= 32'h0000_0000;
      slv_reg_ack_reg  <= 1'b0;
      slv_ee_rdata_reg <= 8'h00;
      slv_ee_ack_reg   <= 1'b0;
      loading_reg      <= 1'b0;
      complete_reg     <= 1'b0;
      rollover_reg     <= 1'b0;
      blank_flag_reg   <= 1'b0;
      unmapped_reg     <= 1'b0;
      cserr_reg        <= 1'b0;
      nack_err_reg     <= 1'b0;
      halt_reg         <= 1'b0;
    end else begin
      slv_reg_ack_reg <= 1'b0;
      slv_ee_ack_reg  <= 1'b0;
      if (eng_valid)
        issued_reg <= 1'b1;
      if (eng_done)
        issued_reg <= 1'b0;
      case (state_reg)
        S_BOOT: begin
          presc_reg <= slow_s_reg ? SLOW_QTR : FAST_QTR;
          if (EE_MODE_MASK[mode_s_reg]) begin
            loading_reg <= 1'b1;
            state_reg   <= S_ST1;
          end else begin
            state_reg <= S_IDLE;
          end
        end
        S_ST1: if (eng_done) state_reg <= S_DEVW;
        S_ST2: if (eng_done) state_reg <= S_DEVR;
        S_DEVW, S_AH, S_AL, S_DEVR, S_EWD: begin
          if (eng_done) begin
            if (eng_nack) begin
              nack_err_reg <= 1'b1;
              if (!ext_reg)
                halt_reg <= 1'b1;
              state_reg <= S_STOP;
            end else if (state_reg == S_DEVW) begin
              state_reg <= S_AH;
            end else if (state_reg == S_AH) begin
              state_reg <= S_AL;
            end else if (state_reg == S_AL) begin
              state_reg <= (ext_reg && xwe_reg) ? S_EWD : S_ST2;
            end else if (state_reg == S_DEVR) begin
              state_reg <= S_RD;
            end else begin
              state_reg <= S_STOP;
            end
          end
        end
        S_RD: begin
          if (!ext_reg && wrap_reg) begin
            rollover_reg <= 1'b1;
            halt_reg     <= 1'b1;
            state_reg    <= fin_st;
          end else if (eng_done) begin
            ack_sent_reg <= rd_ack;
            if (ext_reg) begin
              slv_ee_rdata_reg <= eng_dout;
              state_reg        <= S_STOP;
            end else begin
              state_reg <= S_CONS;
            end
          end
        end
        S_CONS: begin
          ee_addr_reg <= ee_addr_reg + 16'h0001;
          wrap_reg    <= (ee_addr_reg == `SECL_EE_TOP);
          sum_reg     <= sum_n;
          blank_reg   <= blank_n;
          state_reg   <= S_RD;
          if (probe_reg) begin
            if (!blank_n) begin
              if (done_bad_reg) begin
                halt_reg  <= 1'b1;
                cserr_reg <= 1'b1;
              end
              state_reg <= fin_st;
            end else if (ee_addr_reg == `SECL_BLANK_LAST) begin
              blank_flag_reg <= 1'b1;
              state_reg      <= fin_st;
            end
          end else if (pos_reg == `SECL_POS_TYPE) begin
            type_reg     <= b[7:6];
            seq_data_reg <= 1'b0;
            pos_reg      <= `SECL_POS_ADDR_L;
            if (b[7:6] == `SECL_TYPE_BAD) begin
              halt_reg  <= 1'b1;
              cserr_reg <= 1'b1;
              state_reg <= fin_st;
            end
          end else if (type_reg == `SECL_TYPE_DONE) begin
            if (blank_n) begin
              probe_reg    <= 1'b1;
              done_bad_reg <= csum_bad;
            end else begin
              if (csum_bad) begin
                halt_reg  <= 1'b1;
                cserr_reg <= 1'b1;
              end
              state_reg <= fin_st;
            end
          end else if (pos_reg == `SECL_POS_ADDR_L) begin
            daddr_reg[7:0] <= b;
            pos_reg        <= `SECL_POS_ADDR_H;
          end else if (pos_reg == `SECL_POS_ADDR_H) begin
            daddr_reg[15:8] <= b;
            pos_reg         <= `SECL_POS_DATA0;
          end else if (type_reg == `SECL_TYPE_SEQ && !seq_data_reg) begin
            if (pos_reg == `SECL_POS_CNT_L) begin
              count_reg[7:0] <= b;
              pos_reg        <= `SECL_POS_CNT_H;
            end else begin
              count_reg[15:8] <= b;
              seq_data_reg    <= 1'b1;
              pos_reg         <= ({b, count_reg[7:0]} == 16'h0000) ? `SECL_POS_TYPE : `SECL_POS_DATA0;
            end
          end else begin
            data_reg <= {b, data_reg[31:8]};
            pos_reg  <= pos_reg + 3'h1;
            if (pos_reg == `SECL_POS_DATA3) begin
              reg_addr_reg  <= {daddr_reg, 2'b00};
              reg_wdata_reg <= {b, data_reg[31:8]};
              state_reg     <= S_WR;
              if (type_reg == `SECL_TYPE_SEQ && count_reg != 16'h0001) begin
                pos_reg <= `SECL_POS_DATA0;
              end else begin
                pos_reg <= `SECL_POS_TYPE;
              end
            end
          end
        end
        S_WR: begin
          if (!reg_addr_mapped_i)
            unmapped_reg <= 1'b1;
          daddr_reg <= daddr_reg + 16'h0001;
          count_reg <= count_reg - 16'h0001;
          state_reg <= S_RD;
        end
        S_ABRT: if (eng_done) state_reg <= S_STOP;
        S_STOP: begin
          if (eng_done) begin
            if (ext_reg) begin
              slv_ee_ack_reg <= 1'b1;
              state_reg      <= S_IDLE;
            end else begin
              state_reg <= S_FIN;
            end
          end
        end
        S_FIN: begin
          complete_reg <= 1'b1;
          loading_reg  <= 1'b0;
          state_reg    <= S_IDLE;
        end
        S_IDLE: begin
          if (slv_ee_req_i) begin
            ext_reg      <= 1'b1;
            xwe_reg      <= slv_ee_we_i;
            ee_addr_reg  <= slv_ee_addr_i;
            ee_wdata_reg <= slv_ee_wdata_i;
            state_reg    <= S_ST1;
          end else if (slv_reg_req_i) begin
            xwe_reg       <= slv_reg_we_i;
            reg_addr_reg  <= slv_reg_addr_i;
            reg_wdata_reg <= slv_reg_wdata_i;
            state_reg     <= S_XREG;
          end
        end
        S_XREG: begin
          slv_rdata_reg   <= xwe_reg ? 32'h0000_0000 : reg_rdata_i;
          slv_reg_ack_reg <= 1'b1;
          state_reg       <= S_IDLE;
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // single master engine; no arbitration logic exists
  secl_i2c_byte u_byte (
    .clk_sys_i   (clk_sys_i),
    .rst_i       (rst_i),
    .quarter_i   (presc_reg),
    .cmd_valid_i (eng_valid),
    .cmd_i       (eng_cmd),
    .din_i       (eng_din),
    .ack_i       (eng_ack),
    .busy_o      (eng_busy),
    .done_o      (eng_done),
    .dout_o      (eng_dout),
    .nack_o      (eng_nack),
    .scl_i       (scl_i),
    .scl_oe_o    (scl_oe_o),
    .sda_i       (sda_i),
    .sda_oe_o    (sda_oe_o)
  );

endmodule
`default_nettype wire

/* File: tb/secl_loader_props.sv */
// checker for the eeprom configuration loader
`default_nettype none
module secl_loader_props #(parameter logic [15:0] EE_MODE_MASK = 16'h0001) (
  input wire logic        clk_sys_i,
  input wire logic        rst_i,
  input wire logic        master_slow_mode_strap_i,
  input wire logic [3:0]  switch_operating_mode_i,
  input wire logic [17:0] reg_addr_o,
  input wire logic        reg_wr_o,
  input wire logic        reg_rd_o,
  input wire logic        reg_addr_mapped_i,
  input wire logic        slv_ready_o,
  input wire logic        slv_reg_req_i,
  input wire logic        slv_reg_we_i,
  input wire logic [17:0] slv_reg_addr_i,
  input wire logic        slv_ee_req_i,
  input wire logic        slv_reg_ack_o,
  input wire logic [7:0]  master_clock_prescaler_o,
  input wire logic        loading_o,
  input wire logic        load_complete_flag_o,
  input wire logic        checksum_error_flag_o,
  input wire logic        reset_halt_flag_o
);
  timeunit 1ns;
  timeprecision 1ns;
  wire take = slv_ready_o && slv_reg_req_i && !slv_ee_req_i;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  chk_wr_mapped: assert property (reg_wr_o |-> reg_addr_mapped_i && reg_addr_o[1:0] == 2'h0)
    else $error("bad write strobe");
  chk_slave_ack: assert property (take |-> ##2 slv_reg_ack_o)
    else $error("slave access not acknowledged");
  chk_slave_read: assert property (take && !slv_reg_we_i |=> reg_rd_o && reg_addr_o == $past(slv_reg_addr_i))
    else $error("slave read strobe wrong");
  chk_clock_strap: assert property ($fell(rst_i) |=>
    master_clock_prescaler_o == (master_slow_mode_strap_i ? 8'h32 : 8'h0D)) else $error("prescaler wrong");
  chk_mode_gate: assert property ($fell(rst_i) |=> loading_o == EE_MODE_MASK[switch_operating_mode_i])
    else $error("load start wrong");
  chk_done_flag: assert property ($fell(loading_o) |-> ##[0:1] load_complete_flag_o)
    else $error("no completion flag");
  chk_stop_after: assert property ($rose(load_complete_flag_o) |-> ##[0:2] !loading_o)
    else $error("loading after done");
  chk_error_halt: assert property ($rose(checksum_error_flag_o) |-> ##[0:2] reset_halt_flag_o)
    else $error("error without halt");
  cover property (reg_wr_o);
  cover property (take);
  cover property (load_complete_flag_o && reset_halt_flag_o);
endmodule
bind secl_loader secl_loader_props #(.EE_MODE_MASK(EE_MODE_MASK)) i_secl_loader_props (
  .clk_sys_i, .rst_i, .master_slow_mode_strap_i, .switch_operating_mode_i, .reg_addr_o, .reg_wr_o,
  .reg_rd_o, .reg_addr_mapped_i, .slv_ready_o, .slv_reg_req_i, .slv_reg_we_i, .slv_reg_addr_i,
  .slv_ee_req_i, .slv_reg_ack_o, .master_clock_prescaler_o, .loading_o, .load_complete_flag_o,
  .checksum_error_flag_o, .reset_halt_flag_o);
`default_nettype wire

/* File: tb/secl_ee_model.sv */
// behavioural serial eeprom on the two-wire bus
`default_nettype none
module secl_ee_model #(parameter logic [6:0] DEV = 7'h55) (
  input  wire logic scl_i,
  input  wire logic sda_i,
  output var  logic sda_oe_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0]  mem [0:65535];
  logic [7:0]  sh = 0;
  logic [15:0] adr = 0;
  logic [2:0]  ph = 0;
  logic [3:0]  bc = 0;
  logic        nk = 0;
  initial begin
    sda_oe_o = 0;
    for (int i = 0; i < 65536; i++) mem[i] = 8'hFF;
  end
  // slave only, never drives the clock
  always @(negedge sda_i) if (scl_i) begin
    ph = 1;
    bc = 0;
  end
  always @(posedge sda_i) if (scl_i) ph = 0;
  always @(posedge scl_i) if (ph != 0) begin
    if (bc < 8) sh = {sh[6:0], sda_i};
    else nk = sda_i;
    bc = bc + 1;
  end
  always @(negedge scl_i) if (ph != 0) begin
    if (bc == 8) begin
      sda_oe_o = 0;
      case (ph)
        1: if (sh[7:1] == DEV) begin
          sda_oe_o = 1;
          if (sh[0]) begin ph = 5; adr = adr - 1; end
          else ph = 2;
        end else ph = 0;
        2: begin sda_oe_o = 1; adr[15:8] = sh; ph = 3; end
        3: begin sda_oe_o = 1; adr[7:0] = sh; ph = 4; end
        4: begin sda_oe_o = 1; mem[adr] = sh; adr = adr + 1; end
        default: ;
      endcase
    end else if (bc == 9) begin
      bc = 0;
      sda_oe_o = 0;
      if (ph == 5 && nk) ph = 0;
      else if (ph == 5) begin adr = adr + 1; sda_oe_o = ~mem[adr][7]; end
    end else if (ph == 5) sda_oe_o = ~mem[adr][7 - bc];
  end
endmodule
`default_nettype wire

/* File: tb/secl_loader_tb.sv */
// testbench for the eeprom configuration loader
`default_nettype none
module secl_loader_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys_i = 0, rst_i = 1, strap = 0, ign = 0, sreq = 0, swe = 0, ereq = 0, ewe = 0;
  logic [3:0]  mode = 0, straps = 4'h5;
  logic [17:0] saddr = 0;
  logic [31:0] sdat = 0;
  logic [15:0] eaddr = 0;
  logic [7:0]  edat = 0, cs = 0;
  logic [49:0] wlog [$];
  int          pp = 0, num_errors = 0, n_compared = 0;
  wire         scl_oe, sda_oe, ee_oe, rwr, ready, rack, eack;
  wire [17:0]  radr;
  wire [31:0]  wdat, srdat;
  wire [7:0]   erdat, presc, flg;
  wire         scl = ~scl_oe;
  wire         sda = ~(sda_oe | ee_oe);
  wire [3:0]   ev = {ready, flg[1], eack, rack};
  initial forever #25 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) if (rwr === 1'b1) wlog.push_back({radr, wdat});
  secl_loader i_secl_loader (
    .clk_sys_i, .rst_i, .master_slow_mode_strap_i(strap), .switch_operating_mode_i(mode),
    .master_addr_straps_i(straps), .ignore_checksum_errors_i(ign), .scl_i(scl), .scl_o(), .scl_oe_o(scl_oe),
    .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe), .reg_addr_o(radr), .reg_wdata_o(wdat), .reg_wr_o(rwr),
    .reg_rd_o(), .reg_addr_mapped_i(~radr[17]), .reg_rdata_i({14'h0, radr}), .slv_ready_o(ready),
    .slv_reg_req_i(sreq), .slv_reg_we_i(swe), .slv_reg_addr_i(saddr), .slv_reg_wdata_i(sdat),
    .slv_reg_ack_o(rack), .slv_reg_rdata_o(srdat), .slv_ee_req_i(ereq), .slv_ee_we_i(ewe),
    .slv_ee_addr_i(eaddr), .slv_ee_wdata_i(edat), .slv_ee_ack_o(eack), .slv_ee_rdata_o(erdat),
    .master_clock_prescaler_o(presc), .loading_o(flg[0]), .load_complete_flag_o(flg[1]),
    .nack_error_o(flg[2]), .rollover_error_o(flg[3]), .blank_eeprom_o(flg[4]),
    .unmapped_write_flag_o(flg[5]), .checksum_error_flag_o(flg[6]), .reset_halt_flag_o(flg[7]));
  secl_ee_model i_secl_ee_model (.scl_i(scl), .sda_i(sda), .sda_oe_o(ee_oe));
  task automatic end_sim;
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [49:0] got, input logic [49:0] exp);
    n_compared++;
    if (got !== exp) begin num_errors++; $display("Error %0t: got %h want %h", $time, got, exp); end
  endtask
  task automatic wt(input int b, input int n);
    int k = 0;
    do begin @(negedge clk_sys_i); k++; end while (ev[b] !== 1'b1 && k < n);
    if (ev[b] !== 1'b1) begin num_errors++; $display("Error %0t: wait ran out", $time); end_sim; end
  endtask
  task automatic sreg(input logic we, input logic [17:0] a, input logic [31:0] d);
    wt(3, 50);
    @(posedge clk_sys_i);
    sreq <= 1; swe <= we; saddr <= a; sdat <= d;
    @(posedge clk_sys_i);
    sreq <= 0;
    wt(0, 10);
  endtask
  task automatic see(input logic we, input logic [15:0] a, input logic [7:0] d);
    wt(3, 50);
    @(posedge clk_sys_i);
    ereq <= 1; ewe <= we; eaddr <= a; edat <= d;
    @(posedge clk_sys_i);
    ereq <= 0;
    wt(1, 30000);
  endtask
  task automatic boot(input logic s, input logic [3:0] m, input logic ig);
    @(posedge clk_sys_i);
    rst_i <= 1; strap <= s; mode <= m; ign <= ig;
    repeat (3) @(posedge clk_sys_i);
    rst_i <= 0;
    wlog.delete();
  endtask
  task automatic pb(input logic [7:0] b);
    i_secl_ee_model.mem[pp] = b; cs = cs + b; pp++;
  endtask
  task automatic pw(input logic [31:0] w);
    pb(w[7:0]); pb(w[15:8]); pb(w[23:16]); pb(w[31:24]);
  endtask
  task automatic img(input logic [7:0] adj);
    for (int i = 0; i < 300; i++) i_secl_ee_model.mem[i] = 8'hFF;
    pp = 0; cs = 0;
  endtask
  task automatic done_blk(input logic [7:0] adj);
    pb(8'hC0); pb(8'hFF - cs + adj);
  endtask
  task automatic run(input logic ig, input logic [7:0] fx);
    boot(0, 4'h0, ig);
    wt(2, 40000);
    repeat (2) @(negedge clk_sys_i);
    chk(flg, fx);
    $display("load test done");
  endtask
  initial begin
    boot(1, 4'h1, 0);
    wt(3, 10);
    chk(presc, 8'h32);
    chk(flg[0], 1'b0);
    sreg(1, 18'h0_0010, 32'hCAFE_F00D);
    chk(wlog[0], {18'h0_0010, 32'hCAFE_F00D});
    sreg(0, 18'h0_1234, 32'h0);
    chk(srdat, 32'h0000_1234);
    see(1, 16'h0123, 8'h5A);
    chk(i_secl_ee_model.mem[16'h0123], 8'h5A);
    see(0, 16'h0123, 8'h00);
    chk(erdat, 8'h5A);
    $display("slave test done");
    img(0);
    pb(8'h00); pb(8'h34); pb(8'h12); pw(32'h1122_3344);
    pb(8'h40); pb(8'h00); pb(8'h01); pb(8'h02); pb(8'h00); pw(32'hAABB_CCDD); pw(32'h0102_0304);
    pb(8'h40); pb(8'h00); pb(8'h00); pb(8'h00); pb(8'h00);
    pb(8'h00); pb(8'h00); pb(8'h90); pw(32'h5555_AAAA);
    done_blk(0);
    run(0, 8'h22);
    chk(presc, 8'h0D);
    chk(wlog.size(), 3);
    chk(wlog[0], {18'h0_48D0, 32'h1122_3344});
    chk(wlog[1], {18'h0_0400, 32'hAABB_CCDD});
    chk(wlog[2], {18'h0_0404, 32'h0102_0304});
    img(0); pb(8'h80);
    run(0, 8'hC2);
    img(0); done_blk(1);
    run(0, 8'hC2);
    img(0); done_blk(1);
    run(1, 8'h02);
    @(posedge clk_sys_i) straps <= 4'h4;
    run(0, 8'h86);
    end_sim;
  end
endmodule
`default_nettype wire
